// >>> rtl/ssc_pkg.sv
// shared constants for the sweep and segment control block
package ssc_pkg;
	// register addresses on the link
	localparam logic [7:0] A_MAIN  = 8'h00;
	localparam logic [7:0] A_ANLG  = 8'h01;
	localparam logic [7:0] A_BASE  = 8'h04;
	localparam logic [7:0] A_PHASE = 8'h05;
	localparam logic [7:0] A_UPPER = 8'h06;
	localparam logic [7:0] A_SEG0  = 8'h07;
	localparam logic [7:0] A_SEG1  = 8'h08;
	localparam logic [7:0] A_SEG3  = 8'h0a;
	localparam int NREG = 11;
	// widths
	localparam int W_MAIN  = 32;
	localparam int W_ANLG  = 24;
	localparam int W_TUNE  = 32;
	localparam int W_PHASE = 16;
	localparam int W_SEG   = 40;
	localparam int W_PH    = 14;
	// main control word bits
	localparam int B_SWEEP_EN = 21;
	localparam int B_AUTOCLR  = 13;
	localparam int B_CLR_PH   = 10;
	// analog control word fields
	localparam int B_MULT_HI = 7;
	localparam int B_MULT_LO = 3;
	localparam int B_VCO_HI  = 2;
	// segment word fields
	localparam int B_DWELL_HI = 39;
	localparam int B_DWELL_LO = 24;
	localparam int B_NODWELL  = 4;
	localparam int B_MODE_HI  = 7;
	localparam int B_MODE_LO  = 5;
	localparam logic [2:0] MODE_MAX = 3'h4;
	// sweep word fields
	localparam int B_RAMP_HI = 39;
	localparam int B_RAMP_LO = 32;
	// sync clock is core clock divided by four
	localparam int SYNC_DIV = 4;
	localparam logic [1:0] SYNC_LAST = 2'(SYNC_DIV - 1);
	// host apb registers
	localparam logic [7:0] H_CMD     = 8'h00;
	localparam logic [7:0] H_DATA_LO = 8'h04;
	localparam logic [7:0] H_DATA_HI = 8'h08;
	localparam logic [7:0] H_STATUS  = 8'h0c;
	localparam logic [7:0] H_UPDATE  = 8'h10;
	localparam logic [7:0] H_RD_LO   = 8'h14;
	localparam logic [7:0] H_RD_HI   = 8'h18;
	localparam int C_WE = 8;
	localparam int C_GO = 9;
	localparam int S_BUSY = 0;
	localparam int S_ERR  = 1;
	localparam int S_DONE = 2;
endpackage : ssc_pkg

// >>> rtl/ssc_link_if.sv
// register link between the host end and the synthesizer end
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if;
	logic        req;
	logic        we;
	logic [7:0]  addr;
	logic [39:0] wdata;
	logic        ack;
	logic [39:0] rdata;
	logic        io_update;
	modport dev (input req, we, addr, wdata, io_update, output ack, rdata);
	modport host (output req, we, addr, wdata, io_update, input ack, rdata);
endinterface : ssc_link_if
`default_nettype wire

// >>> rtl/ssc_device.sv
// synthesizer end: register buffers, tuning, phase and linear sweep
//
// Summary of operation
// - sweep off: 0x07-0x0A are segment words
// - bits 39:24 give 16-bit dwell count
// - host writes dwell of 1 to 65535
// - final address = bits 9:8 then 23:16
// - begin address = bits 3:0 then 15:10
// - bit 4 picks final or beginning hold
// - host writes mode codes 0 to 4
// - main 0, analog 1, base 4, phase 5
// - host writes main word in full
// - bit 13 clears phase accumulator on update
// - analog bits 7:3 multiplier, bit 2 vco
// - writes buffered, applied on io update
// - output frequency = word / 2^32 * clock
// - phase word added to every sample
// - main bit 21 enables linear sweep
// - sweep word: ramp byte, 32-bit delta
// - ramp byte sets sync periods per step
// - sync clock is core clock over four
// - sweep clamps at upper and base words
// - sweep on: 0x07 falling, 0x08 rising
// - autoclear holds accumulator zero one cycle
`timescale 1ns/1ps
`default_nettype none
module ssc_device (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// link
	ssc_link_if.dev          lk,
	// user side controls
	input  wire logic        sweep_up,
	input  wire logic [1:0]  seg_sel,
	// user side results
	output logic [31:0]      tuning_word,
	output logic [13:0]      phase_word,
	output logic             sync_clk,
	output logic             sweep_on,
	output logic [4:0]       clk_mult,
	output logic             vco_high,
	output logic [15:0]      seg_dwell,
	output logic [9:0]       seg_begin,
	output logic [9:0]       seg_final,
	output logic [2:0]       seg_mode,
	output logic             seg_nodwell
);

	typedef struct packed {
		logic [ssc_pkg::NREG-1:0][39:0] pend;
		logic [ssc_pkg::NREG-1:0][39:0] live;
		logic [31:0]                    acc;
		logic [31:0]                    ftw;
		logic [13:0]                    ph;
		logic [7:0]                     ramp;
		logic [1:0]                     div;
		logic                           ack;
		logic [39:0]                    rdata;
	} ssc_dev_st_t;

	ssc_dev_st_t s;
	ssc_dev_st_t n;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [39:0] reg_mask(input logic [7:0] a);
		case (a)
			ssc_pkg::A_MAIN:  reg_mask = 40'((64'h1 << ssc_pkg::W_MAIN) - 64'h1);
			ssc_pkg::A_ANLG:  reg_mask = 40'((64'h1 << ssc_pkg::W_ANLG) - 64'h1);
			ssc_pkg::A_BASE,
			ssc_pkg::A_UPPER: reg_mask = 40'((64'h1 << ssc_pkg::W_TUNE) - 64'h1);
			ssc_pkg::A_PHASE: reg_mask = 40'((64'h1 << ssc_pkg::W_PHASE) - 64'h1);
			default: begin
				if (a >= ssc_pkg::A_SEG0 && a <= ssc_pkg::A_SEG3) begin
					reg_mask = 40'hff_ffff_ffff;
				end else begin
					reg_mask = 40'h00_0000_0000;
				end
			end
		endcase
	endfunction : reg_mask

	function automatic logic [9:0] final_addr(input logic [39:0] w);
		final_addr = {w[9:8], w[23:16]};
	endfunction : final_addr

	function automatic logic [9:0] begin_addr(input logic [39:0] w);
		begin_addr = {w[3:0], w[15:10]};
	endfunction : begin_addr

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic [3:0]  idx;
	logic        mapped;
	logic        tick;
	logic [39:0] sw_word;
	logic [31:0] delta;
	logic [31:0] upper;
	logic [31:0] lower;
	logic [32:0] sum;

	always_comb begin
		n       = s;
		n.ack   = 1'b0;
		idx     = lk.addr[3:0];
		mapped  = reg_mask(lk.addr) != 40'h00_0000_0000;
		tick    = s.div == ssc_pkg::SYNC_LAST;
		upper   = s.live[ssc_pkg::A_UPPER][31:0];
		lower   = s.live[ssc_pkg::A_BASE][31:0];
		sw_word = sweep_up ? s.live[ssc_pkg::A_SEG1] : s.live[ssc_pkg::A_SEG0];
		delta   = sw_word[31:0];
		sum     = 33'h0_0000_0000;
		n.div   = s.div + 2'h1;

		// link access, one-cycle registered answer
		if (lk.req && !s.ack) begin
			n.ack   = 1'b1;
			n.rdata = mapped ? s.pend[idx] : 40'h00_0000_0000;
			if (lk.we && mapped) begin
				n.pend[idx] = lk.wdata & reg_mask(lk.addr);
			end
		end

		// phase accumulator and offset
		n.acc = s.acc + s.ftw;
		n.ph  = s.acc[31:18] + s.live[ssc_pkg::A_PHASE][13:0];
		if (s.live[ssc_pkg::A_MAIN][ssc_pkg::B_CLR_PH]) begin
			n.acc = 32'h0000_0000;
		end

		// frequency: fixed base word or linear sweep
		if (!s.live[ssc_pkg::A_MAIN][ssc_pkg::B_SWEEP_EN]) begin
			n.ftw = lower;
		end else if (tick) begin
			if (s.ramp <= 8'h01) begin
				n.ramp = sw_word[ssc_pkg::B_RAMP_HI:ssc_pkg::B_RAMP_LO];
				if (sweep_up) begin
					sum = {1'b0, s.ftw} + {1'b0, delta};
					n.ftw = (sum > {1'b0, upper}) ? upper : sum[31:0];
				end else begin
					sum = {1'b0, lower} + {1'b0, delta};
					n.ftw = ({1'b0, s.ftw} < sum) ? lower : s.ftw - delta;
				end
			end else begin
				n.ramp = s.ramp - 8'h01;
			end
		end

		// io update moves buffers into the live registers
		if (lk.io_update) begin
			n.live = n.pend;
			n.ftw  = n.pend[ssc_pkg::A_BASE][31:0];
			n.ramp = 8'h00;
			if (n.pend[ssc_pkg::A_MAIN][ssc_pkg::B_AUTOCLR]) begin
				n.acc = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	logic [39:0] seg_w;

	assign lk.ack   = s.ack;
	assign lk.rdata = s.rdata;

	assign tuning_word = s.ftw;
	assign phase_word  = s.ph;
	assign sync_clk    = s.div[1];
	assign sweep_on    = s.live[ssc_pkg::A_MAIN][ssc_pkg::B_SWEEP_EN];
	assign clk_mult    = s.live[ssc_pkg::A_ANLG][ssc_pkg::B_MULT_HI:ssc_pkg::B_MULT_LO];
	assign vco_high    = s.live[ssc_pkg::A_ANLG][ssc_pkg::B_VCO_HI];

	// segment fields only while sweep is off
	assign seg_w = sweep_on ? 40'h00_0000_0000
	                        : s.live[4'(ssc_pkg::A_SEG0) + {2'h0, seg_sel}];
	assign seg_dwell   = seg_w[ssc_pkg::B_DWELL_HI:ssc_pkg::B_DWELL_LO];
	assign seg_final   = final_addr(seg_w);
	assign seg_begin   = begin_addr(seg_w);
	assign seg_mode    = seg_w[ssc_pkg::B_MODE_HI:ssc_pkg::B_MODE_LO];
	assign seg_nodwell = seg_w[ssc_pkg::B_NODWELL];

endmodule : ssc_device
`default_nettype wire

// >>> rtl/ssc_host.sv
// host end: apb command registers driving the register link
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	ssc_link_if.host         lk
);

	typedef enum logic [0:0] {ST_IDLE, ST_REQ} ssc_hst_state_t;

	typedef struct packed {
		ssc_hst_state_t st;
		logic [7:0]     addr;
		logic           we;
		logic [31:0]    lo;
		logic [7:0]     hi;
		logic [39:0]    rd;
		logic           req;
		logic           upd;
		logic           err;
		logic           done;
		logic           sweep_pend;
		logic           sweep_live;
	} ssc_hst_st_t;

	ssc_hst_st_t s;
	ssc_hst_st_t n;

	logic        wr;
	logic        mapped;
	logic        seg_chk;
	logic        bad;
	logic [15:0] dwell;
	logic [2:0]  mode;

	////////////////////////////////////////////////////////////////////////////
	// register writes and link sequencing

	always_comb begin
		n       = s;
		n.upd   = 1'b0;
		wr      = psel && penable && pwrite;
		mapped  = paddr == ssc_pkg::H_CMD || paddr == ssc_pkg::H_DATA_LO
		       || paddr == ssc_pkg::H_DATA_HI || paddr == ssc_pkg::H_STATUS
		       || paddr == ssc_pkg::H_UPDATE || paddr == ssc_pkg::H_RD_LO
		       || paddr == ssc_pkg::H_RD_HI;
		dwell   = {s.hi, s.lo[31:24]};
		mode    = s.lo[ssc_pkg::B_MODE_HI:ssc_pkg::B_MODE_LO];
		seg_chk = pwdata[7:0] >= ssc_pkg::A_SEG0 && pwdata[7:0] <= ssc_pkg::A_SEG3
		       && !(s.sweep_live && pwdata[7:0] <= ssc_pkg::A_SEG1);
		bad     = pwdata[ssc_pkg::C_WE] && seg_chk
		       && (dwell == 16'h0000 || mode > ssc_pkg::MODE_MAX);

		if (s.st == ST_REQ && lk.ack) begin
			n.st   = ST_IDLE;
			n.req  = 1'b0;
			n.rd   = lk.rdata;
			n.done = 1'b1;
		end

		if (wr) begin
			case (paddr)
				ssc_pkg::H_DATA_LO: n.lo = pwdata;
				ssc_pkg::H_DATA_HI: n.hi = pwdata[7:0];
				ssc_pkg::H_UPDATE: begin
					if (pwdata[0] && s.st == ST_IDLE) begin
						n.upd        = 1'b1;
						n.sweep_live = s.sweep_pend;
					end
				end
				ssc_pkg::H_STATUS: begin
					if (pwdata[ssc_pkg::S_ERR]) begin
						n.err = 1'b0;
					end
					if (pwdata[ssc_pkg::S_DONE] && !(s.st == ST_REQ && lk.ack)) begin
						n.done = 1'b0;
					end
				end
				ssc_pkg::H_CMD: begin
					if (pwdata[ssc_pkg::C_GO] && s.st == ST_IDLE) begin
						if (bad) begin
							n.err = 1'b1;
						end else begin
							n.st   = ST_REQ;
							n.req  = 1'b1;
							n.addr = pwdata[7:0];
							n.we   = pwdata[ssc_pkg::C_WE];
							if (pwdata[ssc_pkg::C_WE] && pwdata[7:0] == ssc_pkg::A_MAIN) begin
								n.sweep_pend = s.lo[ssc_pkg::B_SWEEP_EN];
							end
						end
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb read side and link drive

	always_comb begin
		case (paddr)
			ssc_pkg::H_CMD:     prdata = {22'h0, s.we, 1'b0, s.addr};
			ssc_pkg::H_DATA_LO: prdata = s.lo;
			ssc_pkg::H_DATA_HI: prdata = {24'h0, s.hi};
			ssc_pkg::H_STATUS:  prdata = {29'h0, s.done, s.err, s.st == ST_REQ};
			ssc_pkg::H_RD_LO:   prdata = s.rd[31:0];
			ssc_pkg::H_RD_HI:   prdata = {24'h0, s.rd[39:32]};
			default:            prdata = 32'h0000_0000;
		endcase
	end

	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign lk.req       = s.req;
	assign lk.we        = s.we;
	assign lk.addr      = s.addr;
	assign lk.wdata     = {s.hi, s.lo};
	assign lk.io_update = s.upd;

endmodule : ssc_host
`default_nettype wire

// >>> tb/ssc_props.sv
// link checker for the sweep and segment control block
`timescale 1ns/1ps
`default_nettype none
module ssc_props (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// link
	input wire logic        req,
	input wire logic        we,
	input wire logic [7:0]  addr,
	input wire logic [39:0] wdata,
	input wire logic        ack,
	input wire logic [39:0] rdata,
	input wire logic        io_update
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ack_next; req && !ack |=> ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("late ack");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	property p_ack_req; ack |-> req; endproperty
	a_ack_req: assert property (p_ack_req) else $error("stray ack");
	property p_req_hold;
		req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request moved");
	property p_unmap;
		ack && !we && (addr inside {8'h02, 8'h03} || addr > 8'h0a) |-> rdata == 40'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_main_w; ack && !we && addr == 8'h00 |-> rdata[39:32] == 8'h0; endproperty
	a_main_w: assert property (p_main_w) else $error("main width");
	property p_anlg_w; ack && !we && addr == 8'h01 |-> rdata[39:24] == 16'h0; endproperty
	a_anlg_w: assert property (p_anlg_w) else $error("analog width");
	property p_phase_w; ack && !we && addr == 8'h05 |-> rdata[39:16] == 24'h0; endproperty
	a_phase_w: assert property (p_phase_w) else $error("phase width");
	property p_io_pulse; io_update |=> !io_update; endproperty
	a_io_pulse: assert property (p_io_pulse) else $error("long update");
	property p_io_idle; io_update |-> !req; endproperty
	a_io_idle: assert property (p_io_idle) else $error("update while busy");
endmodule : ssc_props
`default_nettype wire

// >>> tb/ssc_bench.sv
// self-checking bench joining host and synthesizer ends
`timescale 1ns/1ps
`default_nettype none
module ssc_bench;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic        sweep_up, sync_clk, sweep_on, vco_high, seg_nodwell;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv, tuning_word;
	logic [1:0]  seg_sel;
	logic [13:0] phase_word;
	logic [4:0]  clk_mult;
	logic [15:0] seg_dwell;
	logic [9:0]  seg_begin, seg_final;
	logic [2:0]  seg_mode;
	logic [39:0] lv;
	int          errors = 0, check_count = 0, gn;
	logic [1:0]  sa [3] = '{2'h0, 2'h1, 2'h3};
	logic [39:0] sw [3] = '{40'h0100630020, 40'h0100c79021, 40'hffffffff9f};
	logic [39:0] se [3] = '{40'h010018c002, 40'h010031c642, 40'hfffffffff9};
	ssc_link_if  lk ();
	always #10 pclk = ~pclk;
	ssc_host i_ssc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lk(lk));
	ssc_device i_ssc_device (.pclk(pclk), .presetn(presetn), .lk(lk), .sweep_up(sweep_up),
		.seg_sel(seg_sel), .tuning_word(tuning_word), .phase_word(phase_word),
		.sync_clk(sync_clk), .sweep_on(sweep_on), .clk_mult(clk_mult), .vco_high(vco_high),
		.seg_dwell(seg_dwell), .seg_begin(seg_begin), .seg_final(seg_final),
		.seg_mode(seg_mode), .seg_nodwell(seg_nodwell));
	ssc_props i_ssc_props (.pclk(pclk), .presetn(presetn), .req(lk.req), .we(lk.we),
		.addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata),
		.io_update(lk.io_update));
	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rv = prdata;
		serr = pslverr;
		if (pready !== 1'b1) begin
			errors++;
			finish_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic poll();
		int n;
		n = 0;
		do begin
			apb(1'b0, ssc_pkg::H_STATUS, 32'h0);
			n++;
		end while (rv[0] !== 1'b0 && n < 20);
		if (rv[0] !== 1'b0) begin
			errors++;
			finish_test();
		end
		chk(rv[0], 1'b0);
	endtask : poll
	task automatic lk_wr(input logic [7:0] a, input logic [39:0] d);
		apb(1'b1, ssc_pkg::H_DATA_LO, d[31:0]);
		apb(1'b1, ssc_pkg::H_DATA_HI, {24'h0, d[39:32]});
		apb(1'b1, ssc_pkg::H_CMD, {22'h0, 2'h3, a});
		poll();
	endtask : lk_wr
	task automatic lk_rd(input logic [7:0] a);
		apb(1'b1, ssc_pkg::H_CMD, {22'h0, 2'h2, a});
		poll();
		apb(1'b0, ssc_pkg::H_RD_LO, 32'h0);
		lv[31:0] = rv;
		apb(1'b0, ssc_pkg::H_RD_HI, 32'h0);
		lv[39:32] = rv[7:0];
	endtask : lk_rd
	task automatic upd();
		apb(1'b1, ssc_pkg::H_UPDATE, 32'h1);
		repeat (3) @(posedge pclk);
	endtask : upd
	// cycles between two tuning steps
	task automatic gap();
		logic [31:0] t;
		for (int k = 0; k < 2; k++) begin
			t = tuning_word;
			gn = 0;
			do begin
				@(posedge pclk);
				gn++;
			end while (tuning_word === t && gn < 40);
			if (tuning_word === t) begin
				errors++;
				finish_test();
			end
		end
	endtask : gap
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (50000) @(posedge pclk);
		errors++;
		finish_test();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		sweep_up = 1'b0;
		seg_sel = 2'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		lk_wr(ssc_pkg::A_ANLG, 40'hffff0000a4);
		chk(clk_mult, 5'h0);
		lk_rd(ssc_pkg::A_ANLG);
		chk(lv, 40'ha4);
		upd();
		chk({vco_high, clk_mult}, 6'h34);
		// sync clock: half period of two core edges
		rv[0] = sync_clk;
		repeat (2) @(posedge pclk);
		chk(sync_clk, !rv[0]);
		repeat (2) @(posedge pclk);
		chk(sync_clk, rv[0]);
		for (int i = 0; i < 3; i++)
			lk_wr(8'h07 + {6'h0, sa[i]}, sw[i]);
		upd();
		for (int i = 0; i < 3; i++) begin
			seg_sel <= sa[i];
			repeat (2) @(posedge pclk);
			chk({seg_dwell, seg_final, seg_begin, seg_mode, seg_nodwell}, se[i]);
		end
		// mode five and zero dwell are refused
		lk_wr(ssc_pkg::A_SEG0, 40'h01000000a0);
		chk(rv[1], 1'b1);
		apb(1'b1, ssc_pkg::H_STATUS, 32'h2);
		lk_wr(ssc_pkg::A_SEG0, 40'h0000000020);
		chk(rv[1], 1'b1);
		apb(1'b1, ssc_pkg::H_STATUS, 32'h2);
		lk_rd(ssc_pkg::A_SEG0);
		chk(lv, sw[0]);
		apb(1'b0, 8'h1c, 32'h0);
		chk({serr, rv}, {1'b1, 32'h0});
		// done flag set by the last access, cleared by writing one
		apb(1'b0, ssc_pkg::H_STATUS, 32'h0);
		chk(rv[2:0], 3'h4);
		apb(1'b1, ssc_pkg::H_STATUS, 32'h4);
		apb(1'b0, ssc_pkg::H_STATUS, 32'h0);
		chk(rv[2:0], 3'h0);
		lk_rd(8'h02);
		chk(lv, 40'h0);
		apb(1'b0, ssc_pkg::H_CMD, 32'h0);
		chk(rv, 32'h0000_0002);
		lk_wr(ssc_pkg::A_BASE, 40'h4e147ae1);
		lk_wr(ssc_pkg::A_PHASE, 40'hffff0800);
		lk_wr(ssc_pkg::A_MAIN, 40'h00002400);
		upd();
		repeat (4) @(posedge pclk);
		chk(tuning_word, 32'h4e147ae1);
		chk(phase_word, 14'h0800);
		lk_rd(ssc_pkg::A_PHASE);
		chk(lv, 40'h0800);
		lk_rd(ssc_pkg::A_MAIN);
		chk(lv, 40'h2400);
		// free running accumulator, then autoclear alone on the next update
		lk_wr(ssc_pkg::A_MAIN, 40'h0);
		upd();
		lk_wr(ssc_pkg::A_MAIN, 40'h00002000);
		upd();
		chk(phase_word, 14'h0800);
		@(posedge pclk);
		chk(phase_word, 14'h1b85);
		// linear sweep between base and upper words
		lk_wr(ssc_pkg::A_BASE, 40'h100);
		lk_wr(ssc_pkg::A_UPPER, 40'h135);
		lk_wr(ssc_pkg::A_SEG1, 40'h0100000010);
		lk_wr(ssc_pkg::A_SEG0, 40'h0200000008);
		lk_wr(ssc_pkg::A_MAIN, 40'h00200000);
		sweep_up <= 1'b1;
		upd();
		chk({sweep_on, seg_dwell, seg_mode}, 20'h80000);
		gap();
		chk(40'(gn), 40'h4);
		repeat (40) @(posedge pclk);
		chk(tuning_word, 32'h135);
		sweep_up <= 1'b0;
		gap();
		chk(40'(gn), 40'h8);
		repeat (100) @(posedge pclk);
		chk(tuning_word, 32'h100);
		// sweep on: word at 0x07 is a sweep word, no dwell check
		lk_wr(ssc_pkg::A_SEG0, 40'h0000000008);
		chk(rv[1], 1'b0);
		finish_test();
	end
endmodule : ssc_bench
`default_nettype wire
